// ==== hw/srg_pkg.sv ====
package srg_pkg;
   // ==========================================================
   // motion states, gray along idle-accel-run-decel
   typedef enum logic [1:0] {
      SRG_IDLE = 2'b00,
      SRG_ACCEL = 2'b01,
      SRG_RUN = 2'b11,
      SRG_DECEL = 2'b10
   } srg_state_type;

   // driver-facing controls travel together
   typedef struct packed {
      logic step;
      logic dir;
      logic decay;
      logic ext_mode;
      logic enable;
      logic [3:0] res;
   } srg_drive_type;
endpackage

// ==== hw/srg_regs.svh ====
`ifndef SRG_REGS_SVH
`define SRG_REGS_SVH
// ==========================================================
// register offsets
`define SRG_CMD_ADDR 8'h00
`define SRG_CFG_ADDR 8'h04
`define SRG_START_ADDR 8'h08
`define SRG_TARGET_ADDR 8'h0C
`define SRG_STOPSPD_ADDR 8'h10
`define SRG_ACCEL_ADDR 8'h14
`define SRG_COUNT_ADDR 8'h18
`define SRG_DECELAT_ADDR 8'h1C
`define SRG_STATUS_ADDR 8'h20
`define SRG_DONE_ADDR 8'h24
`define SRG_PERIOD_ADDR 8'h28
// ==========================================================
// field positions
`define SRG_CMD_RUN 0
`define SRG_CMD_STOP 1
`define SRG_CMD_MOVE 2
`define SRG_CFG_DIR 0
`define SRG_CFG_DECAY 1
`define SRG_CFG_EXT 2
`define SRG_CFG_RES_LO 4
`define SRG_CFG_EN 8
// ==========================================================
// limits and reset values
`define SRG_PERIOD_MIN 16'h007B
`define SRG_PERIOD_MAX 16'h9C40
`define SRG_ACCEL_MAX 13'h1388
`define SRG_RES_INT_MAX 4'h5
`define SRG_RES_EXT_MIN 4'h1
`define SRG_RES_EXT_MAX 4'h9
`define SRG_PERIOD_RST 16'h9C40
// ==========================================================
// timing
`define SRG_CLK_HZ 20000000
`define SRG_TICK_HZ 8000000
`define SRG_PULSE_NS 1000
`define SRG_PULSE_TICKS ((`SRG_PULSE_NS * (`SRG_TICK_HZ / 1000000) + 999) / 1000)
`define SRG_UPD_BASE 16'h1770
`define SRG_UPD_MIN 16'h03E8
`define SRG_RAMP_STEP 16'h0001
`endif

// ==== hw/srg_step_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "srg_regs.svh"
module srg_step_gen
   import srg_pkg::*;
#(
   parameter int CNT_W = 32
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output srg_drive_type drive,
   output logic busy
);
   // ==========================================================
   // 8 MHz tick from 20 MHz: add 2, wrap at 5
   // the tick is a one-cycle enable; every timer below stays on core_clk
   // ticks land 2 or 3 core cycles apart, exact over any five cycles
   // a fractional divider avoids a second clock domain and its crossings
   logic [2:0] frac_q;
   logic tick_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         frac_q <= 3'h0;
         tick_q <= 1'b0;
      end else if (frac_q >= 3'h3) begin
         frac_q <= frac_q - 3'h3;
         tick_q <= 1'b1;
      end else begin
         frac_q <= frac_q + 3'h2;
         tick_q <= 1'b0;
      end
   end

   // ==========================================================
   // configuration registers
   // speeds are held as periods in ticks, so a larger value is slower
   // software converts steps per second to ticks before writing
   // the step counters are CNT_W wide; a longer move wraps the compare
   // dir, decay, ext and enable are plain bits copied onto the driver pins
   logic [15:0] start_q, target_q, stopspd_q;
   logic [12:0] accel_q;
   logic [CNT_W-1:0] count_q, decel_at_q, done_q;
   logic dir_q, decay_q, ext_q, en_q;
   logic [3:0] res_q;
   srg_state_type state_q;
   logic [15:0] period_q;
   logic move_q;

   // period clamp keeps speed within 200..65040 step pulses per second
   // values saturate instead of wrapping, so a slip in software never
   // commands a speed outside what the driver was set up for
   function automatic logic [15:0] clamp_period(input logic [31:0] v);
      if (v < {16'h0000, `SRG_PERIOD_MIN}) begin
         clamp_period = `SRG_PERIOD_MIN;
      end else if (v > {16'h0000, `SRG_PERIOD_MAX}) begin
         clamp_period = `SRG_PERIOD_MAX;
      end else begin
         clamp_period = v[15:0];
      end
   endfunction

   // resolution clamp per indexer mode
   // internal indexing tops out at 1/32; external needs at least half step
   // the clamp keeps a bad code from reaching the driver's select pins
   function automatic logic [3:0] clamp_res(input logic [3:0] r, input logic ext);
      if (!ext) begin
         clamp_res = (r > `SRG_RES_INT_MAX) ? `SRG_RES_INT_MAX : r;
      end else if (r < `SRG_RES_EXT_MIN) begin
         clamp_res = `SRG_RES_EXT_MIN;
      end else begin
         clamp_res = (r > `SRG_RES_EXT_MAX) ? `SRG_RES_EXT_MAX : r;
      end
   endfunction

   // setup writes land only while idle so motion uses settled values
   // a write while busy is dropped without any flag, so software reads
   // the status word first; the ramp never sees a half-written setup,
   // at the cost of no retuning on the fly
   logic wr_idle;
   assign wr_idle = reg_wr && (state_q == SRG_IDLE);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         start_q <= `SRG_PERIOD_RST;
         target_q <= `SRG_PERIOD_RST;
         stopspd_q <= `SRG_PERIOD_RST;
         accel_q <= 13'h0000;
         count_q <= '0;
         decel_at_q <= '0;
         dir_q <= 1'b0;
         decay_q <= 1'b0;
         ext_q <= 1'b0;
         en_q <= 1'b0;
         res_q <= 4'h0;
      end else if (wr_idle) begin
         if (reg_addr == `SRG_CFG_ADDR) begin
            dir_q <= reg_wdata[`SRG_CFG_DIR];
            decay_q <= reg_wdata[`SRG_CFG_DECAY];
            ext_q <= reg_wdata[`SRG_CFG_EXT];
            en_q <= reg_wdata[`SRG_CFG_EN];
            res_q <= clamp_res(reg_wdata[`SRG_CFG_RES_LO +: 4],
                               reg_wdata[`SRG_CFG_EXT]);
         end else if (reg_addr == `SRG_START_ADDR) begin
            start_q <= clamp_period(reg_wdata);
         end else if (reg_addr == `SRG_TARGET_ADDR) begin
            target_q <= clamp_period(reg_wdata);
         end else if (reg_addr == `SRG_STOPSPD_ADDR) begin
            stopspd_q <= clamp_period(reg_wdata);
         end else if (reg_addr == `SRG_ACCEL_ADDR) begin
            accel_q <= (reg_wdata > 32'(`SRG_ACCEL_MAX)) ?
                       `SRG_ACCEL_MAX : reg_wdata[12:0];
         end else if (reg_addr == `SRG_COUNT_ADDR) begin
            count_q <= reg_wdata[CNT_W-1:0];
         end else if (reg_addr == `SRG_DECELAT_ADDR) begin
            decel_at_q <= reg_wdata[CNT_W-1:0];
         end
      end
   end

   // ==========================================================
   // commands
   // run wins over move when one write sets both bits
   // a move with a zero count is refused, it could never reach its end
   // stop in idle is ignored so a late stop cannot cancel the next start
   // command writes are not subject to the idle gate on setup writes
   logic cmd_hit, go_run, go_move, go_stop;
   assign cmd_hit = reg_wr && (reg_addr == `SRG_CMD_ADDR);
   assign go_run = cmd_hit && reg_wdata[`SRG_CMD_RUN] && (state_q == SRG_IDLE);
   assign go_move = cmd_hit && reg_wdata[`SRG_CMD_MOVE] && !reg_wdata[`SRG_CMD_RUN]
                    && (state_q == SRG_IDLE) && (count_q != '0);
   assign go_stop = cmd_hit && reg_wdata[`SRG_CMD_STOP] && (state_q != SRG_IDLE);

   // ==========================================================
   // step period timer, one pulse each time it reaches the period
   // the period is compared rather than loaded, so a ramp update
   // takes hold on the step already under way
   // the counter clears while idle so the first step waits a full period
   logic [15:0] step_cnt_q;
   logic step_fire;
   assign step_fire = tick_q && (state_q != SRG_IDLE) && (step_cnt_q + 16'h0001 >= period_q);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         step_cnt_q <= 16'h0000;
      end else if (state_q == SRG_IDLE) begin
         step_cnt_q <= 16'h0000;
      end else if (step_fire) begin
         step_cnt_q <= 16'h0000;
      end else if (tick_q) begin
         step_cnt_q <= step_cnt_q + 16'h0001;
      end
   end

   // ==========================================================
   // update timer: interval shortens as acceleration grows
   // the interval is taken once at the start command; accel cannot change
   // mid-motion anyway, since setup writes are refused while busy
   // the floor keeps a large acceleration from shrinking the interval to nothing
   logic [15:0] upd_len_q, upd_cnt_q;
   logic upd_fire;
   assign upd_fire = tick_q && (upd_cnt_q + 16'h0001 >= upd_len_q);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         upd_len_q <= `SRG_UPD_BASE;
         upd_cnt_q <= 16'h0000;
      end else if (go_run || go_move) begin
         // interval derived once, at the start command
         upd_len_q <= (`SRG_UPD_BASE - {3'h0, accel_q} < `SRG_UPD_MIN) ?
                      `SRG_UPD_MIN : `SRG_UPD_BASE - {3'h0, accel_q};
         upd_cnt_q <= 16'h0000;
      end else if (upd_fire || state_q == SRG_IDLE) begin
         upd_cnt_q <= 16'h0000;
      end else if (tick_q) begin
         upd_cnt_q <= upd_cnt_q + 16'h0001;
      end
   end

   // ==========================================================
   // ramp one fixed step toward a goal period, never past it
   // one tick per update trades ramp time for smoothness
   // stopping at the goal keeps the period from hunting around it
   // the same function serves both ramps, so decel mirrors accel exactly
   function automatic logic [15:0] ramp(input logic [15:0] p, input logic [15:0] goal);
      if (p > goal) begin
         ramp = (p - goal > `SRG_RAMP_STEP) ? p - `SRG_RAMP_STEP : goal;
      end else begin
         ramp = (goal - p > `SRG_RAMP_STEP) ? p + `SRG_RAMP_STEP : goal;
      end
   endfunction

   // ==========================================================
   // step counting for move mode
   // done also counts in run mode but is only compared when moving
   // comparing done plus one lets the decision land with the step itself
   // a decelerate point of zero never matches, so that move runs flat out
   logic last_step, decel_step;
   assign last_step = step_fire && move_q && (done_q + 1'b1 == count_q);
   assign decel_step = step_fire && move_q && (done_q + 1'b1 == decel_at_q);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         done_q <= '0;
      end else if (go_run || go_move) begin
         done_q <= '0;
      end else if (step_fire) begin
         done_q <= done_q + 1'b1;
      end
   end

   // ==========================================================
   // motion state machine
   // the last step is checked first, so a move always ends on its count
   // stop and the decelerate point share one path into deceleration
   // reaching the target ends the ramp; run then holds the period steady
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= SRG_IDLE;
         period_q <= `SRG_PERIOD_RST;
         move_q <= 1'b0;
      end else begin
         case (state_q)
            SRG_IDLE: begin
               // motion always opens at the start period, never the target
               if (go_run || go_move) begin
                  period_q <= start_q;
                  move_q <= go_move;
                  state_q <= SRG_ACCEL;
               end
            end
            SRG_ACCEL, SRG_RUN: begin
               if (last_step) begin
                  state_q <= SRG_IDLE;
               end else if (go_stop || decel_step) begin
                  state_q <= SRG_DECEL;
               end else if (state_q == SRG_ACCEL) begin
                  if (period_q == target_q) begin
                     state_q <= SRG_RUN;
                  end else if (upd_fire) begin
                     period_q <= ramp(period_q, target_q);
                  end
               end
            end
            SRG_DECEL: begin
               // last step wins here too, ending a move at the current rate
               if (last_step) begin
                  state_q <= SRG_IDLE;
               end else if (period_q == stopspd_q) begin
                  // run mode halts here; move mode finishes its steps
                  if (!move_q) begin
                     state_q <= SRG_IDLE;
                  end
               end else if (upd_fire) begin
                  period_q <= ramp(period_q, stopspd_q);
               end
            end
            default: begin
               state_q <= SRG_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // step pulse width, counted in timer ticks
   // width rounds up to whole ticks so the driver always sees a full pulse
   // the shortest period is far longer than the pulse, so pulses never merge
   logic [3:0] pulse_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_q <= 4'h0;
      end else if (step_fire) begin
         pulse_q <= 4'(`SRG_PULSE_TICKS);
      end else if (tick_q && pulse_q != 4'h0) begin
         pulse_q <= pulse_q - 4'h1;
      end
   end

   // ==========================================================
   // driver outputs, all registered
   // config levels are copied every cycle; they cannot move during motion
   // because setup writes are refused while busy
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         drive <= '0;
      end else begin
         drive.step <= step_fire || (pulse_q > 4'h1) || (pulse_q == 4'h1 && !tick_q);
         drive.dir <= dir_q;
         drive.decay <= decay_q;
         drive.ext_mode <= ext_q;
         drive.enable <= en_q;
         drive.res <= res_q;
      end
   end

   // ==========================================================
   // busy flag, one cycle behind the state register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_q != SRG_IDLE);
      end
   end

   // ==========================================================
   // read port, data one cycle after the strobe; unmapped reads zero
   // status packs the move flag, the gray state and busy in the low nibble
   // rdata is cleared outside reads so a shared read bus sees no stale word
   // counts wider than 32 bits would be cut here; CNT_W is 32 by default
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == `SRG_CFG_ADDR) begin
         reg_rdata <= {23'h0, en_q, res_q, 1'b0, ext_q, decay_q, dir_q};
      end else if (reg_addr == `SRG_START_ADDR) begin
         reg_rdata <= {16'h0000, start_q};
      end else if (reg_addr == `SRG_TARGET_ADDR) begin
         reg_rdata <= {16'h0000, target_q};
      end else if (reg_addr == `SRG_STOPSPD_ADDR) begin
         reg_rdata <= {16'h0000, stopspd_q};
      end else if (reg_addr == `SRG_ACCEL_ADDR) begin
         reg_rdata <= {19'h0, accel_q};
      end else if (reg_addr == `SRG_COUNT_ADDR) begin
         reg_rdata <= 32'(count_q);
      end else if (reg_addr == `SRG_DECELAT_ADDR) begin
         reg_rdata <= 32'(decel_at_q);
      end else if (reg_addr == `SRG_STATUS_ADDR) begin
         reg_rdata <= {28'h0, move_q, state_q, (state_q != SRG_IDLE)};
      end else if (reg_addr == `SRG_DONE_ADDR) begin
         reg_rdata <= 32'(done_q);
      end else if (reg_addr == `SRG_PERIOD_ADDR) begin
         reg_rdata <= {16'h0000, period_q};
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// ==== sim/srg_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module srg_motor_model
   import srg_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire srg_drive_type drive,
   output logic [31:0] step_cnt,
   output logic [31:0] last_gap,
   output logic [31:0] pos
);
   logic [31:0] gap_q;
   logic signed [31:0] pos_q;
   logic step_q;
   // shaft position in 1/512 steps, read back by the bench
   assign pos = pos_q;
   // power stage: moves only when enabled, by the microstep size, in dir
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         step_cnt <= 32'h0;
         last_gap <= 32'h0;
         gap_q <= 32'h0;
         pos_q <= 32'sh0;
         step_q <= 1'b0;
      end else begin
         step_q <= drive.step;
         gap_q <= gap_q + 32'h1;
         if (drive.step && !step_q && drive.enable) begin
            step_cnt <= step_cnt + 32'h1;
            last_gap <= gap_q + 32'h1;
            gap_q <= 32'h0;
            pos_q <= drive.dir ? pos_q - (32'sd512 >>> drive.res) :
                     pos_q + (32'sd512 >>> drive.res);
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/srg_step_gen_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module srg_step_gen_assertions
   import srg_pkg::*;
#(
   parameter int CNT_W = 32
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire srg_drive_type drive,
   input wire logic busy
);
   // ========
   // helpers
   logic [15:0] gap_q;
   logic [15:0] idle_q;
   logic [31:0] cnt_q;
   logic [31:0] steps_q;
   logic move_q;
   logic step_q;
   wire logic cmd_w = reg_wr && reg_addr == 8'h00 && !busy;
   // step spacing, idle time and move tally; count only latched while idle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_q <= 16'hFFFF;
         idle_q <= 16'h0000;
         cnt_q <= 32'h0000_0000;
         steps_q <= 32'h0000_0000;
         move_q <= 1'b0;
         step_q <= 1'b0;
      end else begin
         step_q <= drive.step;
         gap_q <= (drive.step && !step_q) ? 16'h0000 : gap_q + {15'h0, gap_q != 16'hFFFF};
         idle_q <= busy ? 16'h0000 : idle_q + {15'h0, idle_q != 16'hFFFF};
         if (reg_wr && reg_addr == 8'h18 && !busy) begin
            cnt_q <= reg_wdata;
         end
         if (cmd_w && reg_wdata[2] && !reg_wdata[0]) begin
            steps_q <= 32'h0000_0000;
         end else if (drive.step && !step_q) begin
            steps_q <= steps_q + 32'h1;
         end
         if (cmd_w && (reg_wdata[0] || reg_wdata[2])) begin
            move_q <= !reg_wdata[0];
         end
      end
   end
   // ========
   // properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read cycle");
   step_width_a: assert property ($rose(drive.step) |-> drive.step[*8] ##[1:40] !drive.step)
      else $error("step pulse width out of bounds");
   step_gap_a: assert property ($rose(drive.step) |-> gap_q >= 16'd300)
      else $error("steps closer than fastest period");
   step_idle_a: assert property (drive.step |-> idle_q < 16'd30)
      else $error("step issued while idle");
   cfg_stable_a: assert property (busy && $past(busy) |-> $stable(drive[7:0]))
      else $error("drive config changed during motion");
   res_range_a: assert property (drive.res <= (drive.ext_mode ? 4'h9 : 4'h5)
      && (!drive.ext_mode || drive.res >= 4'h1))
      else $error("resolution code out of range");
   run_start_a: assert property (cmd_w && reg_wdata[0] && !$past(busy) && !$past(reg_wr)
      |-> ##2 busy)
      else $error("run command did not start motion");
   move_count_a: assert property ($fell(busy) && move_q |-> ##2 steps_q == cnt_q)
      else $error("move ended with wrong step count");
endmodule
bind srg_step_gen srg_step_gen_assertions #(.CNT_W(CNT_W)) srg_step_gen_assertions_inst (
   .core_clk(core_clk),
   .reset_n(reset_n),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .drive(drive),
   .busy(busy)
);
`default_nettype wire

// ==== sim/srg_step_gen_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module srg_step_gen_tb
   import srg_pkg::*;
;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} srg_row_type;
   localparam srg_row_type ROWS [11] = '{
      '{1'b0, 8'h08, 32'h0, 32'h9C40}, '{1'b0, 8'h0C, 32'h0, 32'h9C40},
      '{1'b0, 8'h10, 32'h0, 32'h9C40}, '{1'b0, 8'h14, 32'h0, 32'h0},
      '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b0, 8'h24, 32'h0, 32'h0},
      '{1'b0, 8'h28, 32'h0, 32'h9C40}, '{1'b0, 8'h3C, 32'h0, 32'h0},
      '{1'b1, 8'h08, 32'h1, 32'h7B}, '{1'b1, 8'h0C, 32'hFFFF, 32'h9C40},
      '{1'b1, 8'h14, 32'h2000, 32'h1388}};
   localparam logic [31:0] RCFG [3] = '{32'h190, 32'h104, 32'h194};
   localparam logic [3:0] RRES [3] = '{4'h5, 4'h1, 4'h9};
   logic core_clk, reset_n, reg_wr, reg_rd, busy;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, step_cnt, last_gap, pos, v, base;
   srg_drive_type drive;
   int n_mismatch, comparisons;
   srg_step_gen #(.CNT_W(32)) srg_step_gen_inst (.core_clk(core_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .drive(drive), .busy(busy));
   srg_motor_model srg_motor_model_inst (.core_clk(core_clk), .reset_n(reset_n),
      .drive(drive), .step_cnt(step_cnt), .last_gap(last_gap), .pos(pos));
   // 20 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ========
   // bus and check tasks
   task automatic print_verdict();
      $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
      chk(n, e, v);
   endtask
   // n of zero waits for idle, else for the model step tally to reach n
   task automatic wt(input logic [31:0] n, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge core_clk);
         if ((n == 0) ? (busy === 1'b0) : (step_cnt >= n)) return;
      end
      n_mismatch++;
      $display("unexpected wait %0d: expected done, seen timeout", n);
      print_verdict();
   endtask
   // move: start equals target so the ramp up is empty
   task automatic mv(input logic [31:0] sp, input logic [31:0] st, input logic [31:0] c,
         input logic [31:0] at);
      wr(8'h08, sp);
      wr(8'h0C, sp);
      wr(8'h10, st);
      wr(8'h18, c);
      wr(8'h1C, at);
      base = step_cnt;
      wr(8'h00, 32'h4);
      repeat (3) @(posedge core_clk);
   endtask
   // ========
   // main sequence
   initial begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      foreach (ROWS[i]) begin
         if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
         rchk(ROWS[i].a, ROWS[i].e, "reg");
      end
      foreach (RCFG[i]) begin
         wr(8'h04, RCFG[i]);
         repeat (2) @(posedge core_clk);
         chk("res", {28'h0, RRES[i]}, {28'h0, drive.res});
      end
      // run mode: ramp 130 to 125 ticks, stop ramp to 128
      wr(8'h04, 32'h133);
      wr(8'h08, 32'h82);
      wr(8'h0C, 32'h7D);
      wr(8'h10, 32'h80);
      wr(8'h00, 32'h1);
      rchk(8'h28, 32'h82, "period");
      rchk(8'h20, 32'h3, "status");
      wr(8'h04, 32'h0);
      // one update interval of 1000 ticks has passed, the second not yet
      repeat (2600) @(posedge core_clk);
      rchk(8'h28, 32'h81, "period");
      wt(step_cnt + 32'd44, 20000);
      rchk(8'h20, 32'h7, "status");
      rchk(8'h28, 32'h7D, "period");
      wt(step_cnt + 32'd2, 2000);
      chk("gap", 32'h1, {31'h0, last_gap >= 32'd310 && last_gap <= 32'd315});
      chk("cfg", 32'hD3, {24'h0, drive[7:0]});
      wr(8'h00, 32'h2);
      rchk(8'h20, 32'h5, "status");
      wt(32'h0, 20000);
      rchk(8'h28, 32'h80, "period");
      v = step_cnt;
      wr(8'h00, 32'h2);
      repeat (1000) @(posedge core_clk);
      chk("steps", v, step_cnt);
      chk("busy", 32'h0, {31'h0, busy});
      // every step so far went reverse at 1/8 step, 64 units each
      chk("pos", 32'h0 - (step_cnt << 6), pos);
      // move: decelerate point beyond count
      mv(32'h7D, 32'h90, 32'd12, 32'd100);
      wt(32'h0, 20000);
      chk("steps", base + 32'd12, step_cnt);
      rchk(8'h24, 32'd12, "done");
      rchk(8'h28, 32'h7D, "period");
      // move: stop speed reached early, last steps at stop speed
      mv(32'h7D, 32'h7E, 32'd40, 32'd2);
      wt(base + 32'd3, 3000);
      rchk(8'h20, 32'hD, "status");
      wt(base + 32'd30, 20000);
      rchk(8'h28, 32'h7E, "period");
      wt(32'h0, 20000);
      chk("steps", base + 32'd40, step_cnt);
      // move: count runs out mid deceleration
      mv(32'h7D, 32'h90, 32'd6, 32'd1);
      wt(32'h0, 5000);
      chk("steps", base + 32'd6, step_cnt);
      rchk(8'h28, 32'h7D, "period");
      // reset in mid-run clears every output
      wr(8'h00, 32'h1);
      repeat (400) @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("drive", 32'h0, {23'h0, drive});
      chk("busy", 32'h0, {31'h0, busy});
      // second release: outputs stay quiet and setup is back at reset values
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("drive", 32'h0, {23'h0, drive});
      chk("busy", 32'h0, {31'h0, busy});
      rchk(8'h08, 32'h9C40, "start");
      print_verdict();
   end
endmodule
`default_nettype wire
